// ---- shared/nv_access_pkg.sv ----
package nv_access_pkg;

   // ---------------------------------------------------------------
   // Register offsets (I/O space)
   // ---------------------------------------------------------------
   localparam logic [5:0] OFF_CONTROL   = 6'h1C;
   localparam logic [5:0] OFF_DATA      = 6'h1D;
   localparam logic [5:0] OFF_ADDR_LOW  = 6'h1E;
   localparam logic [5:0] OFF_ADDR_HIGH = 6'h1F;
   localparam logic [5:0] OFF_IRQ_STAT  = 6'h20;
   localparam logic [5:0] OFF_IRQ_CLEAR = 6'h21;
   localparam logic [5:0] OFF_IRQ_EN    = 6'h22;

   // ---------------------------------------------------------------
   // Control field positions
   // ---------------------------------------------------------------
   localparam int BIT_READ  = 0;
   localparam int BIT_GO    = 1;
   localparam int BIT_ARM   = 2;
   localparam int BIT_MODE0 = 4;
   localparam int BIT_MODE1 = 5;

   // Interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_READ = 1;
   localparam int IRQ_REJ  = 2;

   // ---------------------------------------------------------------
   // Reset values and counts
   // ---------------------------------------------------------------
   localparam logic [7:0] DATA_RESET   = 8'h00;
   localparam logic [1:0] MODE_RESET   = 2'h0;
   localparam logic [2:0] ARM_CYCLES   = 3'h4;
   localparam logic [2:0] READ_STALL   = 3'h4;
   localparam logic [2:0] PROG_STALL   = 3'h2;

   // Programming times in nanoseconds
   localparam int ATOMIC_TIME_NS = 3400000;
   localparam int SPLIT_TIME_NS  = 1800000;

   typedef enum logic [1:0] {
      MODE_ATOMIC,
      MODE_ERASE,
      MODE_WRITE,
      MODE_RESERVED
   } prog_mode_t;

   typedef enum {
      ST_IDLE,
      ST_PROGRAM
   } prog_state_t;

endpackage : nv_access_pkg

// ---- src/byte_eeprom_access_controller.sv ----
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps

module byte_eeprom_access_controller
   import nv_access_pkg::*;
#(
   parameter int ADDR_W   = 9,
   parameter int OSC_HZ   = 8000000,
   parameter int ATOMIC_TICKS = (ATOMIC_TIME_NS / 1000) * (OSC_HZ / 1000) / 1000,
   parameter int SPLIT_TICKS  = (SPLIT_TIME_NS / 1000) * (OSC_HZ / 1000) / 1000
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Calibrated oscillator tick, one cycle per oscillator period
   input  wire logic       oscTick,
   // Register port
   input  wire logic [5:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdData,
   // Status
   output logic            cpuStall,
   output logic            busy,
   output logic            irq
);

   localparam int DEPTH = 1 << ADDR_W;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0]        store [DEPTH];
   logic [ADDR_W-1:0] nvAddress;
   logic [7:0]        nvData;
   logic [1:0]        programModeField;
   logic              programArm;
   logic [2:0]        armCount;
   logic              programGoBusy;
   prog_state_t       state;
   logic [31:0]       tickCount;
   logic [2:0]        stallCount;
   logic [2:0]        irqStatus;
   logic [2:0]        irqEnable;
   logic [ADDR_W-1:0] opAddr;
   logic [7:0]        opData;
   prog_mode_t        opMode;
   logic [7:0]        oldByte;

   wire ctlWrite = regWrite && regAddr == OFF_CONTROL;
   wire goReq    = ctlWrite && regWrData[BIT_GO];
   wire readReq  = ctlWrite && regWrData[BIT_READ];
   wire startOp  = goReq && programArm && !programGoBusy &&
                   prog_mode_t'(programModeField) != MODE_RESERVED;
   wire readOk   = readReq && !programGoBusy;
   wire opDone   = state == ST_PROGRAM && oscTick && tickCount <= 32'd1;
   wire rejected = (goReq && programGoBusy) || (readReq && programGoBusy);
   wire addrLowWrite  = regWrite && regAddr == OFF_ADDR_LOW && !programGoBusy;
   wire addrHighWrite = regWrite && regAddr == OFF_ADDR_HIGH && !programGoBusy;

   // ---------------------------------------------------------------
   // Address and data registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         nvAddress <= '0;
      end else if (addrLowWrite) begin
         // Bit loops keep narrower variants free of out-of-range slices
         for (int i = 0; i < ADDR_W && i < 8; i++) begin
            nvAddress[i] <= regWrData[i];
         end
      end else if (addrHighWrite) begin
         for (int i = 8; i < ADDR_W; i++) begin
            nvAddress[i] <= regWrData[i - 8];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         nvData <= DATA_RESET;
      end else if (readOk) begin
         nvData <= store[nvAddress];
      end else if (regWrite && regAddr == OFF_DATA) begin
         nvData <= regWrData;
      end
   end

   // ---------------------------------------------------------------
   // Mode field and arm bit
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         if (!programGoBusy) begin
            programModeField <= MODE_RESET;
         end
      end else if (ctlWrite && !programGoBusy) begin
         programModeField <= regWrData[BIT_MODE1:BIT_MODE0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         programArm <= 1'b0;
         armCount   <= '0;
      end else if (ctlWrite && regWrData[BIT_ARM] && !regWrData[BIT_GO]) begin
         programArm <= 1'b1;
         armCount   <= ARM_CYCLES;
      end else if (startOp) begin
         programArm <= 1'b0;
         armCount   <= '0;
      end else if (armCount != 3'h0) begin
         armCount <= armCount - 3'h1;
         if (armCount == 3'h1) begin
            programArm <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Programming sequencer
   // ---------------------------------------------------------------
   // Operation in flight survives reset, as a real cell would finish
   always_ff @(posedge core_clk) begin
      case (state)
         ST_IDLE: begin
            if (startOp && !reset) begin
               state         <= ST_PROGRAM;
               programGoBusy <= 1'b1;
               tickCount     <= (prog_mode_t'(programModeField) == MODE_ATOMIC) ?
                                32'(ATOMIC_TICKS) : 32'(SPLIT_TICKS);
            end else begin
               programGoBusy <= 1'b0;
               tickCount     <= '0;
            end
         end
         ST_PROGRAM: begin
            if (oscTick) begin
               if (opDone) begin
                  state         <= ST_IDLE;
                  programGoBusy <= 1'b0;
               end else begin
                  tickCount <= tickCount - 32'd1;
               end
            end
         end
         default: begin
            state         <= ST_IDLE;
            programGoBusy <= 1'b0;
         end
      endcase
      if (reset && state != ST_PROGRAM) begin
         state         <= ST_IDLE;
         programGoBusy <= 1'b0;
         tickCount     <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Operation latch
   // ---------------------------------------------------------------
   // Target, data and mode freeze at start, so a reset or a data write
   // during programming cannot redirect the cell update
   always_ff @(posedge core_clk) begin
      if (startOp && !reset) begin
         opAddr  <= nvAddress;
         opData  <= nvData;
         opMode  <= prog_mode_t'(programModeField);
         oldByte <= store[nvAddress];
      end
   end

   // Cell array update at completion
   always_ff @(posedge core_clk) begin
      if (opDone) begin
         case (opMode)
            MODE_ATOMIC: store[opAddr] <= opData;
            MODE_ERASE:  store[opAddr] <= 8'hFF;
            MODE_WRITE:  store[opAddr] <= store[opAddr] & opData;
            default:     store[opAddr] <= store[opAddr];
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Processor stall
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         stallCount <= '0;
         cpuStall   <= 1'b0;
      end else if (readOk) begin
         stallCount <= READ_STALL - 3'h1;
         cpuStall   <= 1'b1;
      end else if (startOp) begin
         stallCount <= PROG_STALL - 3'h1;
         cpuStall   <= 1'b1;
      end else if (stallCount != 3'h0) begin
         stallCount <= stallCount - 3'h1;
      end else begin
         cpuStall <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irqStatus <= '0;
      end else begin
         irqStatus <= (irqStatus &
                       ~((regWrite && regAddr == OFF_IRQ_CLEAR) ? regWrData[2:0] : 3'h0))
                      | {rejected, readOk, opDone};
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irqEnable <= '0;
      end else if (regWrite && regAddr == OFF_IRQ_EN) begin
         irqEnable <= regWrData[2:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq  <= 1'b0;
         busy <= 1'b0;
      end else begin
         irq  <= |(irqStatus & irqEnable);
         busy <= programGoBusy;
      end
   end

   // ---------------------------------------------------------------
   // Read-back
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         regRdData <= '0;
      end else if (regRead) begin
         case (regAddr)
            OFF_CONTROL:   regRdData <= {2'b00, programModeField, 1'b0, programArm,
                                         programGoBusy, 1'b0};
            OFF_DATA:      regRdData <= nvData;
            OFF_ADDR_LOW:  regRdData <= 8'(nvAddress);
            OFF_ADDR_HIGH: regRdData <= 8'(nvAddress >> 8);
            OFF_IRQ_STAT:  regRdData <= {5'h00, irqStatus};
            OFF_IRQ_EN:    regRdData <= {5'h00, irqEnable};
            default:       regRdData <= '0;
         endcase
      end else begin
         regRdData <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   read_stall_a: assert property (@(posedge core_clk) disable iff (reset)
      readOk |=> cpuStall [*4]) else $error("read stall not four cycles");
   prog_stall_a: assert property (@(posedge core_clk) disable iff (reset)
      startOp |=> cpuStall [*2] ##1 !cpuStall) else $error("program stall wrong");
   start_busy_a: assert property (@(posedge core_clk) disable iff (reset)
      startOp |=> programGoBusy) else $error("start did not set busy");
   busy_hold_a: assert property (@(posedge core_clk) disable iff (reset)
      programGoBusy && !opDone |=> programGoBusy) else $error("busy dropped early");
   no_start_a: assert property (@(posedge core_clk) disable iff (reset)
      programGoBusy |-> !startOp) else $error("start accepted while busy");
   arm_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      $rose(programArm) |-> ##[1:4] !programArm) else $error("arm stuck");
   mode_hold_a: assert property (@(posedge core_clk) disable iff (reset)
      programGoBusy |=> $stable(programModeField)) else $error("mode changed busy");
   read_ignore_a: assert property (@(posedge core_clk) disable iff (reset)
      readReq && programGoBusy && !(regWrite && regAddr == OFF_DATA) |=> $stable(nvData))
      else $error("read while busy changed data");

   // Start conditions, tick timing and mode reset
   reject_flag_a: assert property (@(posedge core_clk) disable iff (reset)
      goReq && programGoBusy |=> irqStatus[IRQ_REJ])
      else $error("busy go not flagged");
   unarmed_go_a: assert property (@(posedge core_clk) disable iff (reset)
      goReq && !programArm && !programGoBusy |=> !programGoBusy)
      else $error("unarmed go started");
   reserved_go_a: assert property (@(posedge core_clk) disable iff (reset)
      goReq && programModeField == 2'h3 && !programGoBusy |=> !programGoBusy)
      else $error("reserved mode started");
   tick_time_a: assert property (@(posedge core_clk)
      state == ST_PROGRAM && !oscTick |=> state == ST_PROGRAM && $stable(tickCount))
      else $error("timer moved without tick");
   mode_reset_a: assert property (@(posedge core_clk)
      reset && !programGoBusy |=> programModeField == MODE_RESET)
      else $error("mode not cleared by reset");

   // Stored values
   atomic_value_a: assert property (@(posedge core_clk)
      opDone && opMode == MODE_ATOMIC |=> store[opAddr] == opData)
      else $error("atomic byte wrong");
   erase_value_a: assert property (@(posedge core_clk)
      opDone && opMode == MODE_ERASE |=> store[opAddr] == 8'hFF)
      else $error("erased byte wrong");
   write_and_a: assert property (@(posedge core_clk)
      opDone && opMode == MODE_WRITE |=> store[opAddr] == (oldByte & opData))
      else $error("write-only byte wrong");
   read_data_a: assert property (@(posedge core_clk) disable iff (reset)
      readOk |=> nvData == store[nvAddress])
      else $error("read data wrong");

   // Status outputs
   busy_copy_a: assert property (@(posedge core_clk) disable iff (reset)
      programGoBusy |=> busy)
      else $error("busy output late");
   irq_level_a: assert property (@(posedge core_clk) disable iff (reset)
      |(irqStatus & irqEnable) |=> irq)
      else $error("irq not raised");

   // ---------------------------------------------------------------
   // Cover points
   // ---------------------------------------------------------------
   atomic_c: cover property (@(posedge core_clk) startOp && programModeField == 2'h0);
   erase_c:  cover property (@(posedge core_clk) startOp && programModeField == 2'h1);
   write_c:  cover property (@(posedge core_clk) startOp && programModeField == 2'h2);
   read_c:   cover property (@(posedge core_clk) readOk);
   reset_busy_c: cover property (@(posedge core_clk) reset && programGoBusy);

endmodule : byte_eeprom_access_controller

// ---- tb/byte_eeprom_access_controller_test.sv ----
`timescale 1ns/1ps

module byte_eeprom_access_controller_test;
   import nv_access_pkg::*;
   // ----------------------------------------------------------
   // Signals and counters
   // ----------------------------------------------------------
   logic       core_clk = 1'b0;
   logic       reset    = 1'b1;
   logic       oscTick  = 1'b0;
   logic [1:0] div      = 2'h0;
   logic [5:0] regAddr;
   logic [7:0] regWrData;
   logic       regWrite;
   logic       regRead;
   logic [7:0] regRdData;
   logic       cpuStall;
   logic       busy;
   logic       irq;
   logic [7:0] got;
   int         n_fail   = 0;
   int         checks   = 0;
   int         stallCnt = 0;
   int         busyCnt  = 0;
   typedef struct {logic [1:0] m; logic [7:0] d; int dly; logic [7:0] e; int bt;} row_t;
   row_t rows[6] = '{'{2'h0, 8'hA5, 0, 8'hA5, 20}, '{2'h1, 8'h00, 0, 8'hFF, 12},
                     '{2'h2, 8'h3C, 0, 8'h3C, 12}, '{2'h0, 8'h11, -1, 8'h3C, 0},
                     '{2'h0, 8'h22, 6, 8'h3C, 0}, '{2'h3, 8'h44, 0, 8'h3C, 0}};

   `define CHECK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (e)); end end

   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      div     <= div + 2'h1;
      oscTick <= (div == 2'h3);
      if (cpuStall === 1'b1) stallCnt++;
      if (busy === 1'b1) busyCnt++;
   end

   byte_eeprom_access_controller #(.ATOMIC_TICKS(5), .SPLIT_TICKS(3)) dut (
      .core_clk(core_clk), .reset(reset), .oscTick(oscTick), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .cpuStall(cpuStall), .busy(busy), .irq(irq));

   cpu_model cpu (
      .core_clk(core_clk), .busy(busy), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));

   task automatic summarize();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   initial begin
      #200000;
      n_fail++;
      summarize();
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      cpu.rd(OFF_DATA, got);
      `CHECK(got, DATA_RESET)
      cpu.rd(OFF_CONTROL, got);
      `CHECK(got[5:4], MODE_RESET)
      cpu.rd(6'h30, got);
      `CHECK(got, 8'h00)
      // Erase before write-only keeps the stored byte defined
      foreach (rows[i]) begin
         stallCnt = 0;
         busyCnt  = 0;
         cpu.prog_byte(rows[i].m, 9'h105, rows[i].d, rows[i].dly);
         repeat (3) @(posedge core_clk);
         cpu.wait_idle();
         `CHECK(stallCnt, (rows[i].bt > 0) ? 2 : 0)
         `CHECK(busyCnt >= rows[i].bt - 4 && busyCnt <= rows[i].bt + 4, 1'b1)
         stallCnt = 0;
         cpu.fetch(9'h105, got);
         `CHECK(stallCnt, 4)
         `CHECK(got, rows[i].e)
      end
      // Requests while programming is running
      cpu.prog_byte(2'h0, 9'h007, 8'h5A, 0);
      cpu.rd(OFF_CONTROL, got);
      `CHECK(got[1], 1'b1)
      cpu.wr(OFF_CONTROL, 8'h11);
      cpu.wr(OFF_CONTROL, 8'h14);
      cpu.wr(OFF_CONTROL, 8'h12);
      cpu.rd(OFF_DATA, got);
      `CHECK(got, 8'h5A)
      cpu.rd(OFF_IRQ_STAT, got);
      `CHECK(got[IRQ_REJ], 1'b1)
      cpu.wait_idle();
      cpu.rd(OFF_CONTROL, got);
      `CHECK(got[5:4], 2'b00)
      cpu.fetch(9'h007, got);
      `CHECK(got, 8'h5A)
      // Reset during programming: operation and mode survive
      cpu.prog_byte(2'h1, 9'h105, 8'h00, 0);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      cpu.rd(OFF_CONTROL, got);
      `CHECK(got[5:4], 2'b01)
      `CHECK(got[1], 1'b1)
      cpu.fetch(9'h105, got);
      `CHECK(got, 8'hFF)
      // Interrupt enable, mask and clear
      cpu.wr(OFF_IRQ_CLEAR, 8'h07);
      cpu.fetch(9'h007, got);
      cpu.wr(OFF_IRQ_EN, 8'h01);
      repeat (2) @(posedge core_clk);
      `CHECK(irq, 1'b0)
      cpu.wr(OFF_IRQ_EN, 8'h02);
      repeat (2) @(posedge core_clk);
      `CHECK(irq, 1'b1)
      cpu.wr(OFF_IRQ_CLEAR, 8'h07);
      repeat (2) @(posedge core_clk);
      `CHECK(irq, 1'b0)
      cpu.rd(OFF_IRQ_STAT, got);
      `CHECK(got, 8'h00)
      summarize();
   end
endmodule : byte_eeprom_access_controller_test

// ---- tb/cpu_model.sv ----
`timescale 1ns/1ps

module cpu_model
   import nv_access_pkg::*;
(
   // Clock and status
   input  wire logic       core_clk,
   input  wire logic       busy,
   // Register port
   output logic      [5:0] regAddr,
   output logic      [7:0] regWrData,
   output logic            regWrite,
   output logic            regRead,
   input  wire logic [7:0] regRdData
);
   initial begin
      regAddr = 6'h00;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
   end

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge core_clk);
      regWrite  <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask : rd

   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (busy !== 1'b0 && n < 400);
   endtask : wait_idle

   // Negative delay skips the arm write
   task automatic prog_byte(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d,
                            input int dly);
      wait_idle();
      wr(OFF_CONTROL, {2'b00, m, 4'h0});
      wr(OFF_ADDR_HIGH, {7'h00, a[8]});
      wr(OFF_ADDR_LOW, a[7:0]);
      wr(OFF_DATA, d);
      if (dly >= 0) wr(OFF_CONTROL, {2'b00, m, 4'h4});
      repeat (dly > 0 ? dly : 0) @(posedge core_clk);
      wr(OFF_CONTROL, {2'b00, m, 4'h2});
   endtask : prog_byte

   task automatic fetch(input logic [8:0] a, output logic [7:0] d);
      wait_idle();
      wr(OFF_ADDR_HIGH, {7'h00, a[8]});
      wr(OFF_ADDR_LOW, a[7:0]);
      wr(OFF_CONTROL, 8'h01);
      repeat (5) @(posedge core_clk);
      rd(OFF_DATA, d);
   endtask : fetch
endmodule : cpu_model
